/* include/copy_unit_pkg.sv */
// constants and types shared by the parameter copy unit control logic
package copy_unit_pkg;
	// ----------------------------------------
	// slots and transfer sizes
	// ----------------------------------------
	localparam int slot_count = 4;
	localparam int slot_bits = 2;
	localparam int param_count = 16;
	localparam int param_bits = 4;
	localparam logic [7:0] drive_station = 8'h01;
	// ----------------------------------------
	// link framing: 19200 baud, 8 data, no parity, 1 stop
	// ----------------------------------------
	localparam int clk_hz = 200000000;
	localparam int baud_rate = 19200;
	localparam int baud_div = clk_hz / baud_rate;
	localparam int reply_timeout_ms = 100;
	localparam int reply_timeout_cycles = reply_timeout_ms * (clk_hz / 1000);
	localparam int blink_half_ms = 250;
	localparam int blink_half_cycles = blink_half_ms * (clk_hz / 1000);
	// ----------------------------------------
	// modbus function codes
	// ----------------------------------------
	localparam logic [7:0] fn_read = 8'h03;
	localparam logic [7:0] fn_write = 8'h06;
	localparam logic [7:0] fn_error_flag = 8'h80;
	// ----------------------------------------
	// display codes
	// ----------------------------------------
	typedef enum logic [3:0] {
		disp_blank,
		disp_standby,
		disp_busy,
		disp_done,
		comm_fault_code,
		empty_slot_fault_code,
		upload_reject_fault_code,
		firmware_mismatch_fault_code,
		nvm_fault_code,
		drive_error_code,
		disp_keypad
	} disp_code_t;
	// ----------------------------------------
	// operator commands
	// ----------------------------------------
	typedef struct packed {
		logic download;
		logic upload_with_motor_params;
		logic upload_without_motor_params;
		logic erase;
		logic stop_reset;
		logic [1:0] slot;
	} key_cmd_t;
	// ----------------------------------------
	// byte channel to and from a uart
	// ----------------------------------------
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} byte_t;
endpackage

/* logic/copy_unit_ctrl.sv */
// control logic of the parameter copy unit: slots, modbus master, fault display
`timescale 1ns/10ps
// Function
// - four parameter slots, indexed 0 to 3, one chosen per command.
// - a missing or bad drive reply shows the communication fault code.
// - download reads drive settings into the slot, upload writes the slot to the drive.
// - upload comes with or without the motor parameters.
// - across different drive models only the upload without motor parameters is allowed.
// - the low-power drive family only allows the upload without motor parameters.
// - an erase command empties a slot.
// - the interface selection picks copy mode (0) or remote keypad (1) at power on.
// - uploading from an empty slot aborts with the empty slot fault code.
// - reject, firmware and nonvolatile memory faults show their own codes.
// - a drive error reply shows the drive error code (the upload reject code during an upload) until stop/reset.
// - stop/reset stops the drive, clears the fault and returns to copy mode.
// - the display blinks while idle.
module copy_unit_ctrl #(
	parameter int timeout_cycles = copy_unit_pkg::reply_timeout_cycles,
	parameter int blink_cycles = copy_unit_pkg::blink_half_cycles,
	parameter int nparams = copy_unit_pkg::param_count
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// operator keys and setup
	input wire copy_unit_pkg::key_cmd_t key,
	input wire logic iface_sel,
	input wire logic same_model,
	input wire logic low_power_family,
	input wire logic fw_supported,
	input wire logic nvm_fail,
	// uart toward the drive
	output copy_unit_pkg::byte_t tx,
	input wire logic tx_ready,
	input wire copy_unit_pkg::byte_t rx,
	// status
	output copy_unit_pkg::disp_code_t disp_code,
	output logic disp_on,
	output logic keypad_mode,
	output logic drive_stop,
	output logic [3:0] slot_full
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef enum {s_idle, s_send, s_wait, s_next, s_fault} state_t;
	state_t state_reg;
	logic [15:0] slot_mem [copy_unit_pkg::slot_count][nparams];
	logic [3:0] full_reg;
	logic [1:0] slot_reg;
	logic is_upload_reg;
	logic motor_reg;
	logic [copy_unit_pkg::param_bits-1:0] idx_reg;
	logic [2:0] tx_cnt_reg;
	logic [2:0] rx_cnt_reg;
	logic [7:0] rx_buf_reg [4];
	logic [31:0] timer_reg;
	logic [31:0] blink_reg;
	logic blink_on_reg;
	logic boot_reg;
	copy_unit_pkg::disp_code_t fault_reg;
	logic [15:0] wr_data;
	logic [7:0] tx_byte;
	logic [2:0] tx_len;
	logic reply_err;

	// first quarter of the map holds motor data; skipped when excluded
	function automatic logic is_motor(input logic [copy_unit_pkg::param_bits-1:0] i);
		is_motor = (i < copy_unit_pkg::param_bits'(nparams / 4));
	endfunction

	// ----------------------------------------
	// request framing (crc supplied by uart)
	// ----------------------------------------
	assign wr_data = slot_mem[slot_reg][idx_reg];
	assign tx_len = 3'd6;
	always_comb
	begin
		case (tx_cnt_reg)
			3'd0: tx_byte = copy_unit_pkg::drive_station;
			3'd1: tx_byte = is_upload_reg ? copy_unit_pkg::fn_write : copy_unit_pkg::fn_read;
			3'd2: tx_byte = 8'h00;
			3'd3: tx_byte = {4'h0, idx_reg};
			3'd4: tx_byte = is_upload_reg ? wr_data[15:8] : 8'h00;
			3'd5: tx_byte = is_upload_reg ? wr_data[7:0] : 8'h01;
			default: tx_byte = 8'h00;
		endcase
	end
	assign tx.valid = (state_reg == s_send);
	assign tx.data = tx_byte;
	assign reply_err = rx_buf_reg[1][7];

	// ----------------------------------------
	// main sequencer
	// ----------------------------------------
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_reg <= s_idle;
			slot_reg <= 2'h0;
			is_upload_reg <= 1'b0;
			motor_reg <= 1'b0;
			idx_reg <= '0;
			tx_cnt_reg <= 3'h0;
			rx_cnt_reg <= 3'h0;
			timer_reg <= 32'h0;
			fault_reg <= copy_unit_pkg::disp_blank;
			full_reg <= 4'h0;
			keypad_mode <= 1'b0;
			boot_reg <= 1'b1;
			drive_stop <= 1'b0;
		end
		else
		begin
			drive_stop <= 1'b0;
			boot_reg <= 1'b0;
			if (boot_reg)
				keypad_mode <= iface_sel;
			if (key.stop_reset)
			begin
				drive_stop <= 1'b1;
				keypad_mode <= 1'b0;
				fault_reg <= copy_unit_pkg::disp_blank;
				state_reg <= s_idle;
			end
			else
			begin
				case (state_reg)
					s_idle:
					begin
						idx_reg <= '0;
						tx_cnt_reg <= 3'h0;
						rx_cnt_reg <= 3'h0;
						slot_reg <= key.slot;
						if (keypad_mode)
							state_reg <= s_idle;
						else if (nvm_fail && (key.download || key.upload_with_motor_params
							|| key.upload_without_motor_params))
						begin
							fault_reg <= copy_unit_pkg::nvm_fault_code;
							state_reg <= s_fault;
						end
						else if (key.erase)
							full_reg[key.slot] <= 1'b0;
						else if (key.download)
						begin
							if (!fw_supported)
							begin
								fault_reg <= copy_unit_pkg::firmware_mismatch_fault_code;
								state_reg <= s_fault;
							end
							else
							begin
								is_upload_reg <= 1'b0;
								motor_reg <= 1'b1;
								state_reg <= s_send;
							end
						end
						else if (key.upload_with_motor_params || key.upload_without_motor_params)
						begin
							if (!full_reg[key.slot])
							begin
								fault_reg <= copy_unit_pkg::empty_slot_fault_code;
								state_reg <= s_fault;
							end
							else if (!fw_supported)
							begin
								fault_reg <= copy_unit_pkg::firmware_mismatch_fault_code;
								state_reg <= s_fault;
							end
							else if (key.upload_with_motor_params
								&& (!same_model || low_power_family))
							begin
								fault_reg <= copy_unit_pkg::upload_reject_fault_code;
								state_reg <= s_fault;
							end
							else
							begin
								is_upload_reg <= 1'b1;
								motor_reg <= key.upload_with_motor_params;
								idx_reg <= key.upload_with_motor_params ? '0
									: copy_unit_pkg::param_bits'(nparams / 4);
								state_reg <= s_send;
							end
						end
					end
					s_send:
					begin
						if (tx_ready)
						begin
							if (tx_cnt_reg == tx_len - 3'd1)
							begin
								tx_cnt_reg <= 3'h0;
								timer_reg <= 32'h0;
								state_reg <= s_wait;
							end
							else
								tx_cnt_reg <= tx_cnt_reg + 3'd1;
						end
					end
					s_wait:
					begin
						timer_reg <= timer_reg + 32'd1;
						if (rx.valid)
							rx_cnt_reg <= rx_cnt_reg + 3'd1;
						if (timer_reg == 32'(timeout_cycles - 1))
						begin
							fault_reg <= copy_unit_pkg::comm_fault_code;
							state_reg <= s_fault;
						end
						else if (rx.valid && rx_cnt_reg == 3'd4)
						begin
							if (rx_buf_reg[0] != copy_unit_pkg::drive_station)
							begin
								fault_reg <= copy_unit_pkg::comm_fault_code;
								state_reg <= s_fault;
							end
							else if (reply_err)
							begin
								fault_reg <= is_upload_reg ? copy_unit_pkg::upload_reject_fault_code
									: copy_unit_pkg::drive_error_code;
								state_reg <= s_fault;
							end
							else
								state_reg <= s_next;
						end
					end
					s_next:
					begin
						rx_cnt_reg <= 3'h0;
						if (idx_reg == copy_unit_pkg::param_bits'(nparams - 1))
						begin
							if (!is_upload_reg)
								full_reg[slot_reg] <= 1'b1;
							fault_reg <= copy_unit_pkg::disp_done;
							state_reg <= s_idle;
						end
						else
						begin
							idx_reg <= idx_reg + 1'b1;
							state_reg <= s_send;
						end
					end
					s_fault:
						state_reg <= s_fault;
					default:
						state_reg <= s_idle;
				endcase
			end
		end
	end

	// ----------------------------------------
	// reply capture and slot storage
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (state_reg == s_wait && rx.valid && rx_cnt_reg < 3'd4)
			rx_buf_reg[rx_cnt_reg[1:0]] <= rx.data;
		if (state_reg == s_wait && rx.valid && rx_cnt_reg == 3'd4 && !is_upload_reg)
			slot_mem[slot_reg][idx_reg] <= {rx_buf_reg[3], rx.data};
	end

	// ----------------------------------------
	// display and standby blink
	// ----------------------------------------
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			blink_reg <= 32'h0;
			blink_on_reg <= 1'b1;
		end
		else if (state_reg != s_idle)
		begin
			blink_reg <= 32'h0;
			blink_on_reg <= 1'b1;
		end
		else if (blink_reg == 32'(blink_cycles - 1))
		begin
			blink_reg <= 32'h0;
			blink_on_reg <= ~blink_on_reg;
		end
		else
			blink_reg <= blink_reg + 32'd1;
	end
	always_comb
	begin
		if (state_reg == s_fault)
			disp_code = fault_reg;
		else if (keypad_mode)
			disp_code = copy_unit_pkg::disp_keypad;
		else if (state_reg == s_idle)
			disp_code = copy_unit_pkg::disp_standby;
		else
			disp_code = copy_unit_pkg::disp_busy;
	end
	assign disp_on = blink_on_reg;
	assign slot_full = full_reg;
	// ----------------------------------------
	// checks
	// ----------------------------------------
	AST_EMPTY_SLOT: assert property (@(posedge clk) disable iff (!rstn)
		state_reg == s_idle && !keypad_mode && !key.stop_reset && !nvm_fail && !key.erase
		&& !key.download && key.upload_without_motor_params && !full_reg[key.slot]
		|=> state_reg == s_fault && fault_reg == copy_unit_pkg::empty_slot_fault_code)
		else $error("empty slot upload not refused");
	AST_TIMEOUT: assert property (@(posedge clk) disable iff (!rstn)
		state_reg == s_wait && timer_reg == 32'(timeout_cycles - 1) && !key.stop_reset
		|=> disp_code == copy_unit_pkg::comm_fault_code) else $error("timeout without comm fault");
	AST_MODEL_REJECT: assert property (@(posedge clk) disable iff (!rstn)
		state_reg == s_idle && !keypad_mode && !key.stop_reset && !nvm_fail && !key.erase
		&& !key.download && key.upload_with_motor_params && full_reg[key.slot] && fw_supported
		&& (!same_model || low_power_family) |=> fault_reg == copy_unit_pkg::upload_reject_fault_code)
		else $error("motor upload across models");
	AST_SKIP_MOTOR: assert property (@(posedge clk) disable iff (!rstn)
		tx.valid && is_upload_reg && !motor_reg |-> !is_motor(idx_reg)) else $error("motor data sent");
	AST_STATION: assert property (@(posedge clk) disable iff (!rstn)
		tx.valid && tx_cnt_reg == 3'd0 |-> tx.data == 8'h01) else $error("wrong station");
	AST_STOP: assert property (@(posedge clk) disable iff (!rstn)
		key.stop_reset |=> drive_stop && !keypad_mode && state_reg == s_idle) else $error("stop ignored");
	AST_ERASE: assert property (@(posedge clk) disable iff (!rstn)
		state_reg == s_idle && !keypad_mode && !key.stop_reset && key.erase
		&& !key.download && !key.upload_with_motor_params && !key.upload_without_motor_params
		|=> !full_reg[$past(key.slot)]) else $error("erase failed");
	AST_BLINK: assert property (@(posedge clk) disable iff (!rstn)
		state_reg != s_idle |=> disp_on) else $error("display dark while busy");
	AST_FUNC: assert property (@(posedge clk) disable iff (!rstn)
		tx.valid && tx_cnt_reg == 3'd1 |-> tx.data == (is_upload_reg ? 8'h06 : 8'h03))
		else $error("wrong function code");
	COV_DOWNLOAD: cover property (@(posedge clk) disable iff (!rstn)
		state_reg == s_next && !is_upload_reg);
	COV_UPLOAD: cover property (@(posedge clk) disable iff (!rstn)
		state_reg == s_next && is_upload_reg);
	COV_FAULT: cover property (@(posedge clk) disable iff (!rstn) state_reg == s_fault);
endmodule

/* dv/drive_model.sv */
// behavioural drive on the far side of the byte link
`timescale 1ns/10ps
module drive_model (
	// clock
	input wire logic clk,
	// scenario controls
	input wire logic mute,
	input wire logic err_reply,
	input wire logic slow,
	input wire logic clr,
	// byte link
	input wire copy_unit_pkg::byte_t tx,
	output logic tx_ready,
	output copy_unit_pkg::byte_t rx,
	// parameters written by uploads
	output logic [15:0] wr_mask
);
	logic [7:0] req [6];
	logic [7:0] rsp [5];
	logic [15:0] mem [16];
	logic [7:0] fn;
	int nreq = 0;
	int nrsp = 5;
	int gap = 0;
	initial
	begin
		tx_ready = 1'h0;
		rx = '0;
		wr_mask = '0;
	end
	always @(posedge clk)
	begin
		tx_ready <= slow ? ~tx_ready : 1'h1;
		rx.valid <= 1'h0;
		// idle line keeps changing so stale data is never mistaken for a byte
		rx.data <= ~rx.data;
		if (clr)
			wr_mask <= '0;
		if (tx.valid && tx_ready)
		begin
			req[nreq] = tx.data;
			nreq = nreq + 1;
			if (nreq == 6)
			begin
				nreq = 0;
				fn = req[1] | (err_reply ? copy_unit_pkg::fn_error_flag : 8'h00);
				if (req[0] == copy_unit_pkg::drive_station && !mute)
				begin
					nrsp = 0;
					gap = slow ? 20 : 2;
					if (req[1] == copy_unit_pkg::fn_write)
					begin
						mem[req[3][3:0]] = {req[4], req[5]};
						wr_mask[req[3][3:0]] <= 1'h1;
						rsp = '{8'h01, fn, req[3], req[4], req[5]};
					end
					else
						rsp = '{8'h01, fn, 8'h02, 8'hc3, req[3]};
				end
			end
		end
		else if (nrsp < 5)
		begin
			if (gap > 0)
				gap = gap - 1;
			else
			begin
				rx.valid <= 1'h1;
				rx.data <= rsp[nrsp];
				nrsp = nrsp + 1;
				gap = slow ? 20 : 2;
			end
		end
	end
endmodule

/* dv/parameter_copy_unit_control_tb.sv */
// self-checking bench of the copy unit control logic
`timescale 1ns/10ps
module parameter_copy_unit_control_tb;
	typedef struct packed {
		copy_unit_pkg::key_cmd_t key;
		logic same;
		logic lowp;
		copy_unit_pkg::disp_code_t code;
		logic [3:0] full;
		logic [15:0] mask;
	} row_t;
	localparam copy_unit_pkg::disp_code_t sb = copy_unit_pkg::disp_standby;
	localparam copy_unit_pkg::disp_code_t rej = copy_unit_pkg::upload_reject_fault_code;
	localparam copy_unit_pkg::disp_code_t emp = copy_unit_pkg::empty_slot_fault_code;
	row_t rows [9] = '{
		'{7'h42, 1'h1, 1'h0, sb, 4'h4, 16'h0},
		'{7'h22, 1'h1, 1'h0, sb, 4'h4, 16'hffff},
		'{7'h12, 1'h0, 1'h0, sb, 4'h4, 16'hfff0},
		'{7'h22, 1'h0, 1'h0, rej, 4'h4, 16'h0},
		'{7'h22, 1'h1, 1'h1, rej, 4'h4, 16'h0},
		'{7'h11, 1'h1, 1'h0, emp, 4'h4, 16'h0},
		'{7'h43, 1'h1, 1'h0, sb, 4'hc, 16'h0},
		'{7'h0a, 1'h1, 1'h0, sb, 4'h8, 16'h0},
		'{7'h22, 1'h1, 1'h0, emp, 4'h8, 16'h0}};
	logic clk = 1'h0;
	logic rstn = 1'h0;
	copy_unit_pkg::key_cmd_t key = '0;
	logic iface_sel = 1'h0, same_model = 1'h1, low_power_family = 1'h0;
	logic fw_supported = 1'h1, nvm_fail = 1'h0;
	logic mute = 1'h0, err_reply = 1'h0, slow = 1'h0, clr = 1'h0;
	logic tx_ready, disp_on, keypad_mode, drive_stop;
	logic [3:0] slot_full;
	logic [15:0] wr_mask;
	copy_unit_pkg::byte_t tx, rx;
	copy_unit_pkg::disp_code_t disp_code;
	int num_errors = 0;
	int samples_checked = 0;
	int toggles;
	int changes;
	logic last_on;
	always #2.5 clk = ~clk;
	copy_unit_ctrl #(.timeout_cycles(200), .blink_cycles(8)) copy_unit_ctrl_inst (.clk(clk),
		.rstn(rstn), .key(key), .iface_sel(iface_sel), .same_model(same_model),
		.low_power_family(low_power_family), .fw_supported(fw_supported), .nvm_fail(nvm_fail),
		.tx(tx), .tx_ready(tx_ready), .rx(rx), .disp_code(disp_code), .disp_on(disp_on),
		.keypad_mode(keypad_mode), .drive_stop(drive_stop), .slot_full(slot_full));
	drive_model drive_model_inst (.clk(clk), .mute(mute), .err_reply(err_reply), .slow(slow),
		.clr(clr), .tx(tx), .tx_ready(tx_ready), .rx(rx), .wr_mask(wr_mask));
	task automatic check(input logic ok, input string msg);
		samples_checked++;
		if (!ok)
		begin
			num_errors++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask
	// one-cycle key pulse, then wait for the operation to settle
	task automatic run(input copy_unit_pkg::key_cmd_t k);
		int n = 0;
		key = k;
		@(negedge clk);
		key = '0;
		repeat (2) @(negedge clk);
		while (n < 4000 && (disp_code === copy_unit_pkg::disp_busy ||
			disp_code === copy_unit_pkg::disp_done))
		begin
			@(negedge clk);
			n++;
		end
	endtask
	task automatic stop_key;
		logic seen = 1'h0;
		key = 7'h04;
		@(negedge clk);
		key = '0;
		repeat (3)
		begin
			if (drive_stop === 1'h1)
				seen = 1'h1;
			@(negedge clk);
		end
		check(seen === 1'h1, "no drive stop pulse");
		check(disp_code === sb, "not back to standby");
	endtask
	task automatic complete_run;
		$display("checks %0d, mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		#200us;
		num_errors++;
		$display("mismatch at %0t: watchdog expired", $time);
		complete_run();
	end
	initial
	begin
		repeat (20) @(negedge clk);
		check(disp_code === sb && slot_full === 4'h0 && keypad_mode === 1'h0, "reset state");
		check(tx.valid === 1'h0, "send during reset");
		rstn = 1'h1;
		repeat (3) @(negedge clk);
		// ---------------------------------------------
		// table of slot operations, including refused and empty-slot uploads
		// ---------------------------------------------
		foreach (rows[i])
		begin
			same_model = rows[i].same;
			low_power_family = rows[i].lowp;
			clr = 1'h1;
			@(negedge clk);
			clr = 1'h0;
			run(rows[i].key);
			check(disp_code === rows[i].code, "display code");
			check(slot_full === rows[i].full, "slot occupancy");
			check(wr_mask === rows[i].mask, "written parameter set");
			for (int p = 0; p < 16; p++)
				if (rows[i].mask[p])
					check(drive_model_inst.mem[p] === (16'hc300 | p), "uploaded value");
			if (rows[i].code !== sb)
				stop_key();
			$display("row %0d done", i);
		end
		// ---------------------------------------------
		// faults, slow drive, blink, keypad start
		// ---------------------------------------------
		mute = 1'h1;
		run(7'h40);
		check(disp_code === copy_unit_pkg::comm_fault_code, "no comm fault");
		stop_key();
		mute = 1'h0;
		err_reply = 1'h1;
		run(7'h40);
		check(disp_code === copy_unit_pkg::drive_error_code, "no drive error");
		stop_key();
		err_reply = 1'h0;
		fw_supported = 1'h0;
		run(7'h40);
		check(disp_code === copy_unit_pkg::firmware_mismatch_fault_code, "fw fault");
		stop_key();
		fw_supported = 1'h1;
		nvm_fail = 1'h1;
		run(7'h40);
		check(disp_code === copy_unit_pkg::nvm_fault_code, "memory fault");
		stop_key();
		nvm_fail = 1'h0;
		$display("fault tests done");
		slow = 1'h1;
		run(7'h41);
		check(disp_code === sb && slot_full[1] === 1'h1, "slow download");
		slow = 1'h0;
		toggles = 0;
		changes = 0;
		last_on = disp_on;
		repeat (40)
		begin
			@(negedge clk);
			if (disp_on !== last_on)
				changes++;
			last_on = disp_on;
			if (disp_on === 1'h1)
				toggles++;
		end
		check(toggles > 0 && toggles < 40, "display not blinking");
		check(changes == 5, "blink rate");
		$display("slow and blink tests done");
		iface_sel = 1'h1;
		rstn = 1'h0;
		repeat (2) @(negedge clk);
		rstn = 1'h1;
		repeat (3) @(negedge clk);
		iface_sel = 1'h0;
		check(keypad_mode === 1'h1, "keypad start");
		run(7'h40);
		check(slot_full === 4'h0, "command taken in keypad mode");
		stop_key();
		check(keypad_mode === 1'h0, "still in keypad mode");
		$display("keypad test done");
		complete_run();
	end
endmodule
